// ==== hdl/bafe_map.vh ====
// Register map, field positions and serial frame counts of the front end.
// Functional notes
// - No-operation registers sit at 0x00 and 0x7F and affect nothing.
// - Reading a no-operation register keeps serial output at zero throughout.
// - Writes to a no-operation register are discarded without side effects.
// - Status at 0x01 is read-only and summarises device state; writes ignored.
// - Status upper bytes show every interrupt term regardless of enables.
// - Interrupt term bits read one while their condition holds.
// - Status low byte carries the four electrode threshold indications.
// - Address 0x20 reads sample FIFO words in burst while host keeps clocking.
// - Address 0x21 reads one FIFO word per transaction and advances it.
// - Address 0x25 returns the latest beat interval; read-only.
// - FIFO reads at 0x20/0x21 advance the FIFO at serial edge 30; status reads do not.
// - Burst continues one word per 24-edge subframe while data remains.
// - Ended latched status conditions other than overflow clear at edge 32 of a status read.
`ifndef BAFE_MAP_VH
`define BAFE_MAP_VH

`define BAFE_ADDR_NOP_LO   7'h00
`define BAFE_ADDR_STATUS   7'h01
`define BAFE_ADDR_CAL      7'h12
`define BAFE_ADDR_EMUX     7'h14
`define BAFE_ADDR_CHAN     7'h15
`define BAFE_ADDR_BEAT_A   7'h1D
`define BAFE_ADDR_BEAT_B   7'h1E
`define BAFE_ADDR_BURST    7'h20
`define BAFE_ADDR_NORMAL   7'h21
`define BAFE_ADDR_INTERVAL 7'h25
`define BAFE_ADDR_NOP_HI   7'h7F

`define BAFE_MASK_CAL      24'h707FFF
`define BAFE_MASK_EMUX     24'hBF0000
`define BAFE_MASK_CHAN     24'hC37000
`define BAFE_MASK_BEAT_A   24'hFFBF00
`define BAFE_MASK_BEAT_B   24'h3F3700

`define BAFE_RST_CAL       24'h000000
`define BAFE_RST_EMUX      24'h000000
`define BAFE_RST_CHAN      24'h000000
`define BAFE_RST_BEAT_A    24'h000000
`define BAFE_RST_BEAT_B    24'h000000

`define BAFE_ST_FIFO_THR   23
`define BAFE_ST_FIFO_OVF   22
`define BAFE_ST_FAST       21
`define BAFE_ST_DCLOFF     20
`define BAFE_ST_LEAD_ON    11
`define BAFE_ST_BEAT       10
`define BAFE_ST_SAMPLE     9
`define BAFE_ST_PLL        8

`define BAFE_CMD_LAST      4'h7
`define BAFE_POP_EDGE      5'h15
`define BAFE_WORD_LAST     5'h17

`endif

// ==== hdl/bafe_sync.v ====
// Two-stage synchroniser for pin inputs entering the ref_clk domain.
`timescale 1ns/10ps
module bafe_sync #(
   parameter W = 1
) (
   // Clock and reset
   input  wire         ref_clk,
   input  wire         resetn,
   // Data
   input  wire [W-1:0] async_in,
   output wire [W-1:0] sync_out
);
   reg [W-1:0] meta_r;
   reg [W-1:0] sync_r;

   always @(posedge ref_clk) begin
      if (!resetn) begin
         meta_r <= {W{1'b1}};
         sync_r <= {W{1'b1}};
      end else begin
         meta_r <= async_in;
         sync_r <= meta_r;
      end
   end

   assign sync_out = sync_r;
endmodule // bafe_sync

// ==== hdl/bafe_fifo.v ====
// Sample FIFO with valid/ready on both sides.
`timescale 1ns/10ps
module bafe_fifo #(
   parameter W  = 24,
   parameter D  = 4,
   parameter AW = 2
) (
   // Clock and reset
   input  wire         ref_clk,
   input  wire         resetn,
   // Fill side
   input  wire [W-1:0] in_data,
   input  wire         in_valid,
   output reg          in_ready,
   // Drain side
   output wire [W-1:0] out_data,
   output wire         out_valid,
   input  wire         out_ready
);
   reg [W-1:0]  mem [0:D-1];
   reg [AW-1:0] wp_r;
   reg [AW-1:0] rp_r;
   reg [AW:0]   cnt_r;
   reg [AW:0]   cnt_nxt;
   wire         push;
   wire         pop;

   assign out_valid = (cnt_r != {(AW+1){1'b0}});
   assign out_data  = mem[rp_r];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always @* begin
      cnt_nxt = cnt_r;
      if (push & ~pop)
         cnt_nxt = cnt_r + 1'b1;
      else if (pop & ~push)
         cnt_nxt = cnt_r - 1'b1;
   end

   // Pointers wrap as a power of two; keep D equal to 2**AW.
   always @(posedge ref_clk) begin
      if (!resetn) begin
         wp_r     <= {AW{1'b0}};
         rp_r     <= {AW{1'b0}};
         cnt_r    <= {(AW+1){1'b0}};
         in_ready <= 1'b0;
      end else begin
         if (push) begin
            mem[wp_r] <= in_data;
            wp_r      <= wp_r + 1'b1;
         end
         if (pop)
            rp_r <= rp_r + 1'b1;
         cnt_r    <= cnt_nxt;
         in_ready <= (cnt_nxt != D[AW:0]);
      end
   end
endmodule // bafe_fifo

// ==== hdl/bafe_regs.v ====
// Serial register bank of the biopotential front end with its sample FIFO.
`timescale 1ns/10ps
`include "bafe_map.vh"
module bafe_regs #(
   parameter SW = 24,
   parameter FD = 4,
   parameter FA = 2
) (
   // Clock and reset
   input  wire          ref_clk,
   input  wire          resetn,
   // Serial interface pins
   input  wire          spi_cs_n,
   input  wire          spi_sclk,
   input  wire          spi_sdi,
   output reg           spi_sdo,
   output reg           spi_sdo_oe_n,
   // Sample stream into the FIFO
   input  wire [SW-1:0] smp_data,
   input  wire          smp_valid,
   output wire          smp_ready,
   // Condition inputs from the channel logic
   input  wire          fast_recovery_cond,
   input  wire          dc_lead_off_cond,
   input  wire          lead_on_cond,
   input  wire          beat_event,
   input  wire [23:0]   beat_interval_in,
   input  wire          sample_sync,
   input  wire          pll_unlock_cond,
   input  wire [3:0]    threshold_cond,
   // Configuration outputs
   output reg  [23:0]   calibration_config_r,
   output reg  [23:0]   input_mux_config_r,
   output reg  [23:0]   channel_config_r,
   output reg  [23:0]   beat_detect_config_a_r,
   output reg  [23:0]   beat_detect_config_b_r
);
   localparam [1:0] ST_CMD  = 2'b00;
   localparam [1:0] ST_DATA = 2'b01;
   localparam [1:0] ST_HOLD = 2'b10;

   // Write mask per address; zero for read-only and unmapped addresses.
   function [23:0] wmask;
      input [6:0] a;
      begin
         if (a == `BAFE_ADDR_CAL)
            wmask = `BAFE_MASK_CAL;
         else if (a == `BAFE_ADDR_EMUX)
            wmask = `BAFE_MASK_EMUX;
         else if (a == `BAFE_ADDR_CHAN)
            wmask = `BAFE_MASK_CHAN;
         else if (a == `BAFE_ADDR_BEAT_A)
            wmask = `BAFE_MASK_BEAT_A;
         else if (a == `BAFE_ADDR_BEAT_B)
            wmask = `BAFE_MASK_BEAT_B;
         else
            wmask = 24'h000000;
      end
   endfunction

   // Synchronised pins.
   wire [2:0]    pin_s;
   wire          cs_s;
   wire          sclk_s;
   wire          sdi_s;

   // FIFO drain side.
   wire [SW-1:0] fifo_data;
   wire          fifo_vld;
   reg           pop_r;

   // Serial engine state.
   reg  [1:0]    state_r;
   reg  [3:0]    hcnt_r;
   reg  [4:0]    dcnt_r;
   reg  [6:0]    cmd_r;
   reg  [6:0]    addr_r;
   reg           rd_r;
   reg  [23:0]   in_r;
   reg  [23:0]   out_r;
   reg           word_ok_r;
   reg           sclk_q_r;
   reg           stclr_r;

   // Latched status terms.
   reg           ovf_r;
   reg           fast_r;
   reg           dcloff_r;
   reg           lon_r;
   reg           beat_r;
   reg           sample_sync_flag_r;
   reg           pll_r;
   reg  [3:0]    thr_r;
   reg  [23:0]   interval_r;

   wire          rise;
   wire          fall;
   wire          is_fifo;
   wire          is_burst;
   wire [23:0]   in_nxt;
   wire [23:0]   wr_word;
   wire [23:0]   status_word;
   reg  [23:0]   rd_word;

   bafe_sync #(
      .W        (3)
   ) u_sync (
      .ref_clk  (ref_clk),
      .resetn   (resetn),
      .async_in ({spi_cs_n, spi_sclk, spi_sdi}),
      .sync_out (pin_s)
   );

   assign cs_s   = pin_s[2];
   assign sclk_s = pin_s[1];
   assign sdi_s  = pin_s[0];

   bafe_fifo #(
      .W         (SW),
      .D         (FD),
      .AW        (FA)
   ) u_fifo (
      .ref_clk   (ref_clk),
      .resetn    (resetn),
      .in_data   (smp_data),
      .in_valid  (smp_valid),
      .in_ready  (smp_ready),
      .out_data  (fifo_data),
      .out_valid (fifo_vld),
      .out_ready (pop_r)
   );

   assign rise     = sclk_s & ~sclk_q_r;
   assign fall     = ~sclk_s & sclk_q_r;
   assign is_burst = (addr_r == `BAFE_ADDR_BURST);
   assign is_fifo  = is_burst | (addr_r == `BAFE_ADDR_NORMAL);
   assign in_nxt   = {in_r[22:0], sdi_s};
   assign wr_word  = in_nxt & wmask(addr_r);

   // Terms show regardless of any enable; every term is active high.
   assign status_word = {fifo_vld, ovf_r, fast_r, dcloff_r,
                         8'h00,
                         lon_r, beat_r, sample_sync_flag_r, pll_r,
                         4'h0, thr_r};

   // Read data chosen by the address of the command byte.
   always @* begin
      rd_word = 24'h000000;
      if (cmd_r == `BAFE_ADDR_STATUS)
         rd_word = status_word;
      else if (cmd_r == `BAFE_ADDR_BURST ||
               cmd_r == `BAFE_ADDR_NORMAL)
         rd_word = fifo_vld ? fifo_data[23:0] : 24'h000000;
      else if (cmd_r == `BAFE_ADDR_INTERVAL)
         rd_word = interval_r;
      else if (cmd_r == `BAFE_ADDR_CAL)
         rd_word = calibration_config_r;
      else if (cmd_r == `BAFE_ADDR_EMUX)
         rd_word = input_mux_config_r;
      else if (cmd_r == `BAFE_ADDR_CHAN)
         rd_word = channel_config_r;
      else if (cmd_r == `BAFE_ADDR_BEAT_A)
         rd_word = beat_detect_config_a_r;
      else if (cmd_r == `BAFE_ADDR_BEAT_B)
         rd_word = beat_detect_config_b_r;
      else
         rd_word = 24'h000000;
   end

   // Status terms: a new event wins over a clear in the same cycle.
   always @(posedge ref_clk) begin
      if (!resetn) begin
         ovf_r      <= 1'b0;
         fast_r     <= 1'b0;
         dcloff_r   <= 1'b0;
         lon_r      <= 1'b0;
         beat_r     <= 1'b0;
         sample_sync_flag_r     <= 1'b0;
         pll_r      <= 1'b0;
         thr_r      <= 4'h0;
         interval_r <= 24'h000000;
      end else begin
         // Overflow holds until reset; a refused sample sets it.
         ovf_r    <= ovf_r | (smp_valid & ~smp_ready);
         fast_r   <= fast_recovery_cond | (fast_r & ~stclr_r);
         dcloff_r <= dc_lead_off_cond | (dcloff_r & ~stclr_r);
         lon_r    <= lead_on_cond | (lon_r & ~stclr_r);
         beat_r   <= beat_event | (beat_r & ~stclr_r);
         sample_sync_flag_r   <= sample_sync | (sample_sync_flag_r & ~stclr_r);
         pll_r    <= pll_unlock_cond | (pll_r & ~stclr_r);
         thr_r    <= threshold_cond | (thr_r & {4{~stclr_r}});
         if (beat_event)
            interval_r <= beat_interval_in;
      end
   end

   // Serial engine: 7 address bits, a read flag, then 24 data bits.
   always @(posedge ref_clk) begin
      if (!resetn) begin
         state_r                <= ST_CMD;
         hcnt_r                 <= 4'h0;
         dcnt_r                 <= 5'h00;
         cmd_r                  <= 7'h00;
         addr_r                 <= 7'h00;
         rd_r                   <= 1'b0;
         in_r                   <= 24'h000000;
         out_r                  <= 24'h000000;
         word_ok_r              <= 1'b0;
         // Matches the synchroniser's reset level, so no false rise.
         sclk_q_r               <= 1'b1;
         stclr_r                <= 1'b0;
         pop_r                  <= 1'b0;
         spi_sdo                <= 1'b0;
         spi_sdo_oe_n           <= 1'b1;
         calibration_config_r   <= `BAFE_RST_CAL;
         input_mux_config_r     <= `BAFE_RST_EMUX;
         channel_config_r       <= `BAFE_RST_CHAN;
         beat_detect_config_a_r <= `BAFE_RST_BEAT_A;
         beat_detect_config_b_r <= `BAFE_RST_BEAT_B;
      end else begin
         sclk_q_r <= sclk_s;
         pop_r    <= 1'b0;
         stclr_r  <= 1'b0;
         if (cs_s) begin
            state_r      <= ST_CMD;
            hcnt_r       <= 4'h0;
            dcnt_r       <= 5'h00;
            cmd_r        <= 7'h00;
            out_r        <= 24'h000000;
            word_ok_r    <= 1'b0;
            spi_sdo      <= 1'b0;
            spi_sdo_oe_n <= 1'b1;
         end else begin
            spi_sdo_oe_n <= 1'b0;
            if (rise) begin
               case (state_r)
                  ST_CMD: begin
                     hcnt_r <= hcnt_r + 1'b1;
                     if (hcnt_r == `BAFE_CMD_LAST) begin
                        state_r   <= ST_DATA;
                        dcnt_r    <= 5'h00;
                        addr_r    <= cmd_r;
                        rd_r      <= sdi_s;
                        out_r     <= sdi_s ? rd_word : 24'h000000;
                        word_ok_r <= fifo_vld;
                     end else begin
                        cmd_r <= {cmd_r[5:0], sdi_s};
                     end
                  end
                  ST_DATA: begin
                     in_r   <= in_nxt;
                     dcnt_r <= dcnt_r + 1'b1;
                     if (dcnt_r == `BAFE_POP_EDGE && rd_r &&
                         is_fifo && word_ok_r)
                        pop_r <= 1'b1;
                     if (dcnt_r == `BAFE_WORD_LAST) begin
                        if (rd_r &&
                            addr_r == `BAFE_ADDR_STATUS)
                           stclr_r <= 1'b1;
                        if (rd_r && is_burst && fifo_vld) begin
                           out_r     <= fifo_data[23:0];
                           word_ok_r <= 1'b1;
                           dcnt_r    <= 5'h00;
                        end else begin
                           state_r <= ST_HOLD;
                        end
                        if (!rd_r) begin
                           // Masks drop unused bits and unwritable
                           // addresses, including status and no-ops.
                           if (addr_r == `BAFE_ADDR_CAL)
                              calibration_config_r <= wr_word;
                           else if (addr_r == `BAFE_ADDR_EMUX)
                              input_mux_config_r <= wr_word;
                           else if (addr_r == `BAFE_ADDR_CHAN)
                              channel_config_r <= wr_word;
                           else if (addr_r == `BAFE_ADDR_BEAT_A)
                              beat_detect_config_a_r <= wr_word;
                           else if (addr_r == `BAFE_ADDR_BEAT_B)
                              beat_detect_config_b_r <= wr_word;
                           // Other addresses are discarded.
                        end
                     end
                  end
                  default: begin
                     state_r <= ST_HOLD;
                  end
               endcase
            end
            // Data changes on falling edges, MSB first.
            if (fall) begin
               spi_sdo <= out_r[23];
               out_r   <= {out_r[22:0], 1'b0};
            end
         end
      end
   end
endmodule // bafe_regs

// ==== verification/bafe_regs_sva.sv ====
// Concurrent checks on the pins of the serial register bank.
`timescale 1ns/10ps
`include "bafe_map.vh"
module bafe_regs_sva (
   // Clock and reset
   input wire logic        ref_clk,
   input wire logic        resetn,
   // Serial pins
   input wire logic        spi_cs_n,
   input wire logic        spi_sclk,
   input wire logic        spi_sdi,
   input wire logic        spi_sdo,
   input wire logic        spi_sdo_oe_n,
   // Sample stream
   input wire logic        smp_valid,
   input wire logic        smp_ready,
   // Configuration
   input wire logic [23:0] calibration_config_r,
   input wire logic [23:0] input_mux_config_r,
   input wire logic [23:0] channel_config_r,
   input wire logic [23:0] beat_detect_config_a_r,
   input wire logic [23:0] beat_detect_config_b_r
);
   logic [7:0]   cnt_r;
   logic [7:0]   cmd_r;
   logic         sclk_r;
   wire  [119:0] cfg = {calibration_config_r, input_mux_config_r,
      channel_config_r, beat_detect_config_a_r, beat_detect_config_b_r};
   wire          nop = cmd_r[7:1] == `BAFE_ADDR_NOP_LO ||
                       cmd_r[7:1] == `BAFE_ADDR_NOP_HI;
   wire          prot = nop || cmd_r[7:1] == `BAFE_ADDR_STATUS;

   // Counts rising serial edges of the current frame and keeps the command.
   always @(posedge ref_clk) begin
      sclk_r <= spi_sclk;
      if (!resetn || spi_cs_n) begin
         cnt_r <= 8'h00;
         cmd_r <= 8'h00;
      end else if (spi_sclk && !sclk_r) begin
         cnt_r <= cnt_r + 8'h01;
         if (cnt_r < 8'h08)
            cmd_r <= {cmd_r[6:0], spi_sdi};
      end
   end

   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   property p_oe_idle; spi_cs_n [*5] |-> spi_sdo_oe_n; endproperty
   a_oe_idle: assert property (p_oe_idle) else $error("sdo driven idle");
   property p_oe_drive; !spi_cs_n [*5] |-> !spi_sdo_oe_n; endproperty
   a_oe_drive: assert property (p_oe_drive)
      else $error("sdo not driven");
   property p_sdo_stable; spi_sclk [*4] |-> $stable(spi_sdo); endproperty
   a_sdo_stable: assert property (p_sdo_stable)
      else $error("sdo moved");
   property p_ready_fall;
      $fell(smp_ready) |-> $past(smp_valid) || $past(smp_valid, 2);
   endproperty
   a_ready_fall: assert property (p_ready_fall)
      else $error("ready fell");
   property p_cfg_quiet; spi_cs_n [*6] |=> $stable(cfg); endproperty
   a_cfg_quiet: assert property (p_cfg_quiet) else $error("cfg moved");
   property p_nop_protect;
      cnt_r == 8'h20 && !cmd_r[0] && prot |=> $stable(cfg) [*6];
   endproperty
   a_nop_protect: assert property (p_nop_protect)
      else $error("cfg hit");
   property p_nop_read;
      cnt_r > 8'h08 && cmd_r[0] && nop |-> !spi_sdo;
   endproperty
   a_nop_read: assert property (p_nop_read) else $error("nop sdo set");
   property p_mask_a;
      (calibration_config_r & ~`BAFE_MASK_CAL) == 24'h000000 &&
      (input_mux_config_r & ~`BAFE_MASK_EMUX) == 24'h000000 &&
      (channel_config_r & ~`BAFE_MASK_CHAN) == 24'h000000;
   endproperty
   a_mask_a: assert property (p_mask_a) else $error("unused bit set");
   property p_mask_b;
      (beat_detect_config_a_r & ~`BAFE_MASK_BEAT_A) == 24'h000000 &&
      (beat_detect_config_b_r & ~`BAFE_MASK_BEAT_B) == 24'h000000;
   endproperty
   a_mask_b: assert property (p_mask_b) else $error("unused bit set");

   c_nop_read: cover property (cnt_r == 8'h09 && cmd_r[0] && nop);
   c_burst: cover property (cnt_r == 8'h68);
   c_write: cover property (cnt_r == 8'h20 && !cmd_r[0] && !prot);
endmodule // bafe_regs_sva

bind bafe_regs bafe_regs_sva u_sva (.ref_clk(ref_clk), .resetn(resetn),
   .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_sdi(spi_sdi),
   .spi_sdo(spi_sdo), .spi_sdo_oe_n(spi_sdo_oe_n), .smp_valid(smp_valid),
   .smp_ready(smp_ready), .calibration_config_r(calibration_config_r),
   .input_mux_config_r(input_mux_config_r),
   .channel_config_r(channel_config_r),
   .beat_detect_config_a_r(beat_detect_config_a_r),
   .beat_detect_config_b_r(beat_detect_config_b_r));

// ==== verification/bafe_host.sv ====
// Host-side serial master model that frames register transactions.
`timescale 1ns/10ps
module bafe_host (
   // Clock
   input  wire logic ref_clk,
   // Serial pins
   output logic      spi_cs_n,
   output logic      spi_sclk,
   output logic      spi_sdi,
   input  wire logic spi_sdo
);
   logic [23:0] rx_q[$];

   initial begin
      spi_cs_n = 1'b1;
      spi_sclk = 1'b0;
      spi_sdi  = 1'b0;
   end

   // Reads may run extra 24-edge subframes; sdo is taken late in the high
   // phase because the device shifts only a few clocks after the fall.
   task automatic xfer(input logic [6:0] a, input logic rd,
                       input logic [23:0] wd, input int nw);
      logic [31:0] sh;
      logic [23:0] w;
      int          n;
      sh = {a, rd, wd};
      w  = 24'h000000;
      rx_q.delete();
      if (!rd)
         nw = 1;
      @(posedge ref_clk);
      #1 spi_cs_n = 1'b0;
      for (n = 0; n < 8 + 24 * nw; n++) begin
         spi_sdi = (n < 32) ? sh[31-n] : ~spi_sdi;
         repeat (4) @(posedge ref_clk);
         #1 spi_sclk = 1'b1;
         repeat (3) @(posedge ref_clk);
         #1 w = {w[22:0], spi_sdo};
         if (n >= 8 && (n - 8) % 24 == 23)
            rx_q.push_back(w);
         @(posedge ref_clk);
         #1 spi_sclk = 1'b0;
      end
      repeat (4) @(posedge ref_clk);
      #1 spi_cs_n = 1'b1;
      spi_sdi = ~spi_sdi;
      repeat (8) @(posedge ref_clk);
      #1;
   endtask
endmodule // bafe_host

// ==== verification/bafe_regs_tb.sv ====
// Self-checking bench for the serial register bank.
`timescale 1ns/10ps
`include "bafe_map.vh"
module bafe_regs_tb;
   logic        ref_clk;
   logic        resetn;
   wire         spi_cs_n, spi_sclk, spi_sdi, spi_sdo, spi_sdo_oe_n;
   logic [23:0] smp_data;
   logic        smp_valid;
   wire         smp_ready;
   logic        fast_c, dcl_c, lon_c, pll_c, beat_p, sample_sync_flag_p;
   logic [3:0]  thr_c;
   logic [23:0] beat_iv;
   wire  [23:0] cfg [0:4];
   int          err_count;
   int          checks;
   logic [6:0]  ad [0:4] = '{`BAFE_ADDR_CAL, `BAFE_ADDR_EMUX,
      `BAFE_ADDR_CHAN, `BAFE_ADDR_BEAT_A, `BAFE_ADDR_BEAT_B};
   logic [23:0] mk [0:4] = '{`BAFE_MASK_CAL, `BAFE_MASK_EMUX,
      `BAFE_MASK_CHAN, `BAFE_MASK_BEAT_A, `BAFE_MASK_BEAT_B};

   bafe_regs uut (.ref_clk(ref_clk), .resetn(resetn), .spi_cs_n(spi_cs_n),
      .spi_sclk(spi_sclk), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo),
      .spi_sdo_oe_n(spi_sdo_oe_n), .smp_data(smp_data),
      .smp_valid(smp_valid), .smp_ready(smp_ready),
      .fast_recovery_cond(fast_c), .dc_lead_off_cond(dcl_c),
      .lead_on_cond(lon_c), .beat_event(beat_p),
      .beat_interval_in(beat_iv), .sample_sync(sample_sync_flag_p),
      .pll_unlock_cond(pll_c), .threshold_cond(thr_c),
      .calibration_config_r(cfg[0]), .input_mux_config_r(cfg[1]),
      .channel_config_r(cfg[2]), .beat_detect_config_a_r(cfg[3]),
      .beat_detect_config_b_r(cfg[4]));
   bafe_host host (.ref_clk(ref_clk), .spi_cs_n(spi_cs_n),
      .spi_sclk(spi_sclk), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo));

   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h not %h", $time, got, exp);
      end
   endtask

   task automatic test_done;
      $display("checks %0d err_count %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic rd1(input logic [6:0] a, input logic [23:0] exp);
      host.xfer(a, 1'b1, 24'h000000, 1);
      chk(host.rx_q[0], exp);
   endtask

   task automatic push(input logic [23:0] d);
      int k;
      k = 0;
      @(posedge ref_clk);
      #1 smp_data = d;
      smp_valid = 1'b1;
      while (smp_ready !== 1'b1 && k < 20) begin
         @(posedge ref_clk);
         #1 k++;
      end
      @(posedge ref_clk);
      #1 smp_valid = 1'b0;
   endtask

   task automatic t_config;
      int i;
      for (i = 0; i < 5; i++) begin
         chk(cfg[i], 24'h000000);
         host.xfer(ad[i], 1'b0, 24'hFFFFFF, 1);
         chk(cfg[i], mk[i]);
         rd1(ad[i], mk[i]);
      end
   endtask

   // Zero writes to protected places must leave the configs at their masks intact.
   task automatic t_noop;
      logic [6:0] pa [0:5];
      int         i, j;
      pa = '{`BAFE_ADDR_NOP_LO, `BAFE_ADDR_NOP_HI, `BAFE_ADDR_STATUS,
             `BAFE_ADDR_NORMAL, `BAFE_ADDR_INTERVAL, 7'h30};
      for (i = 0; i < 6; i++) begin
         host.xfer(pa[i], 1'b0, 24'h000000, 1);
         for (j = 0; j < 5; j++)
            chk(cfg[j], mk[j]);
      end
      rd1(`BAFE_ADDR_NOP_LO, 24'h000000);
      rd1(`BAFE_ADDR_NOP_HI, 24'h000000);
      rd1(7'h30, 24'h000000);
   endtask

   task automatic t_status;
      @(posedge ref_clk);
      #1 {fast_c, dcl_c, lon_c, pll_c, thr_c, beat_p, sample_sync_flag_p} = 10'h3FF;
      beat_iv = 24'h0ABCDE;
      @(posedge ref_clk);
      #1 {beat_p, sample_sync_flag_p} = 2'b00;
      rd1(`BAFE_ADDR_STATUS, 24'h300F0F);
      rd1(`BAFE_ADDR_INTERVAL, 24'h0ABCDE);
      host.xfer(`BAFE_ADDR_INTERVAL, 1'b0, 24'h000000, 1);
      rd1(`BAFE_ADDR_INTERVAL, 24'h0ABCDE);
      {fast_c, dcl_c, lon_c, pll_c, thr_c} = 8'h00;
      rd1(`BAFE_ADDR_STATUS, 24'h30090F);
      rd1(`BAFE_ADDR_STATUS, 24'h000000);
   endtask

   // Fill until refused, then drain by one normal and one long burst read.
   task automatic t_fifo;
      int i;
      for (i = 0; i < 5; i++)
         push(24'h910003 + i * 24'h010101);
      chk({23'h000000, smp_ready}, 24'h000000);
      rd1(`BAFE_ADDR_STATUS, 24'hC00000);
      rd1(`BAFE_ADDR_NORMAL, 24'h910003);
      chk({23'h000000, smp_ready}, 24'h000001);
      host.xfer(`BAFE_ADDR_BURST, 1'b1, 24'h000000, 4);
      for (i = 0; i < 4; i++)
         chk(host.rx_q[i], i < 3 ? 24'h910003 + (i + 1) * 24'h010101
                                  : 24'h000000);
      rd1(`BAFE_ADDR_STATUS, 24'h400000);
   endtask

   initial begin
      #1200000;
      err_count++;
      $display("unexpected at %0t: watchdog expired", $time);
      test_done;
   end

   initial begin
      err_count = 0;
      checks = 0;
      resetn = 1'b0;
      smp_data = 24'h000000;
      smp_valid = 1'b0;
      {fast_c, dcl_c, lon_c, pll_c, thr_c, beat_p, sample_sync_flag_p} = 10'h000;
      beat_iv = 24'h000000;
      repeat (12) @(posedge ref_clk);
      #1 resetn = 1'b1;
      repeat (4) @(posedge ref_clk);
      #1;
      t_config;
      t_noop;
      t_status;
      t_fifo;
      test_done;
   end
endmodule // bafe_regs_tb
